// file: design/alc_pkg.sv
package alc_pkg;

  // ************************************************************
  // Slice geometry
  // ************************************************************
  localparam int SLICE_W    = 4;
  localparam int NUM_SLICES = 4;

  // ************************************************************
  // Select codes, listed as {select_3, select_2, select_1, select_0}
  // ************************************************************
  localparam logic [3:0] SEL_ADD  = 4'h9;  // Select 0 and 3 high, 1 and 2 low
  localparam logic [3:0] SEL_PASS = 4'h0;  // All select lines low passes A
  localparam logic [3:0] SEL_SUB  = 4'h6;  // Plain default, retune per part
  localparam logic [3:0] SEL_XOR  = 4'h6;  // Same code, taken with mode high

  // ************************************************************
  // Mode and pin polarities
  // ************************************************************
  localparam logic MODE_ARITH       = 1'b0;
  localparam logic MODE_LOGIC       = 1'b1;
  localparam logic CARRY_IN_ACTIVE  = 1'b1;
  localparam logic CARRY_OUT_ACTIVE = 1'b1;

  // ************************************************************
  // User commands
  // ************************************************************
  localparam logic [1:0] OP_ADD      = 2'h0;
  localparam logic [1:0] OP_SUB      = 2'h1;
  localparam logic [1:0] OP_XOR      = 2'h2;
  localparam logic [1:0] OP_ADD_PASS = 2'h3;

  // ************************************************************
  // Timing and reset values
  // ************************************************************
  localparam int          SYNC_STAGES   = 3;
  // Pin change shows at the filter output on the fourth edge; read on the fifth
  localparam int          SETTLE_CYCLES = SYNC_STAGES + 2;
  localparam logic [3:0]  WAIT_RST      = 4'h0;
  localparam logic [2:0]  PASS_RST      = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_CAPTURE
  } alc_state_type;

endpackage

// file: design/alc_sync.sv
`timescale 1ns/1ps

// ************************************************************
// Three stage input filter: change taken when stages 2 and 3 agree
// ************************************************************
module alc_sync
  import alc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic out_r;

      // Stage 1 is seen only by stage 2, to keep metastability contained
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          s1_r  <= 1'b0;
          s2_r  <= 1'b0;
          s3_r  <= 1'b0;
          out_r <= 1'b0;
        end else begin
          s1_r <= i_async[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            out_r <= s3_r;
          end
        end
      end

      assign o_sync[gi] = out_r;
    end
  endgenerate

endmodule // alc_sync

// file: design/alc_host.sv
//Contract
// - Equality outputs are open collector and wired together across slices.
// - Ripple mode: each carry in driven from next lower slice carry out.
// - Active-high auxiliary terms are wired exactly like generate and propagate.
// - Sixteen-bit word from four slices, carry ins supplied per slice.
// - Word equivalence is AND over slices of propagate and generate terms.
// - Add-or-pass: select 0 and 3 tied as control, 1 and 2 low.
`timescale 1ns/1ps

module alc_host
  import alc_pkg::*;
#(
  parameter int N_SLICE = NUM_SLICES
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_sys_rst,
  // User side
  input  wire logic                         i_start,
  input  wire logic [1:0]                   i_op,
  input  wire logic [SLICE_W*N_SLICE-1:0]   i_a,
  input  wire logic [SLICE_W*N_SLICE-1:0]   i_b,
  input  wire logic                         i_carry_active,
  input  wire logic                         i_add_ctrl,
  output logic                              o_busy,
  output logic                              o_done,
  output logic [SLICE_W*N_SLICE-1:0]        o_result,
  output logic                              o_carry_active,
  output logic                              o_all_ones,
  output logic                              o_equivalent,
  // Slice pins
  output logic [SLICE_W*N_SLICE-1:0]        o_operand_a,
  output logic [SLICE_W*N_SLICE-1:0]        o_operand_b,
  output logic                              o_function_select_0,
  output logic                              o_function_select_1,
  output logic                              o_function_select_2,
  output logic                              o_function_select_3,
  output logic                              o_mode,
  output logic [N_SLICE-1:0]                o_carry_in,
  input  wire logic [SLICE_W*N_SLICE-1:0]   i_function_out,
  input  wire logic [N_SLICE-1:0]           i_carry_output,
  input  wire logic [N_SLICE-1:0]           i_group_generate,
  input  wire logic [N_SLICE-1:0]           i_group_propagate,
  input  wire logic                         i_all_ones_wire
);

  localparam int WORD_W = SLICE_W * N_SLICE;
  localparam int SYNC_W = WORD_W + 3 * N_SLICE + 1;

  // ************************************************************
  // Pin input filtering
  // ************************************************************
  logic [SYNC_W-1:0]  pins_raw;
  logic [SYNC_W-1:0]  pins_sync;
  logic [WORD_W-1:0]  f_sync;
  logic [N_SLICE-1:0] cout_sync;
  logic [N_SLICE-1:0] gen_sync;
  logic [N_SLICE-1:0] prop_sync;
  logic               ones_sync;

  // Wired equality arrives as one resolved level from the tied slices
  assign pins_raw = {i_all_ones_wire, i_group_propagate, i_group_generate,
                     i_carry_output, i_function_out};

  alc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (pins_raw),
    .o_sync    (pins_sync)
  );

  assign f_sync    = pins_sync[WORD_W-1:0];
  assign cout_sync = pins_sync[WORD_W +: N_SLICE];
  assign gen_sync  = pins_sync[WORD_W+N_SLICE +: N_SLICE];
  assign prop_sync = pins_sync[WORD_W+2*N_SLICE +: N_SLICE];
  assign ones_sync = pins_sync[SYNC_W-1];

  // ************************************************************
  // Sequencer
  // ************************************************************
  alc_state_type state_r;
  logic [3:0]    wait_r;
  logic [2:0]    pass_r;
  logic          last_wait;
  logic          last_pass;

  // Each pass waits out the filter so the carries seen are settled
  assign last_wait = (wait_r == 4'(SETTLE_CYCLES - 1));
  assign last_pass = (pass_r == 3'(N_SLICE - 1));

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
      wait_r  <= WAIT_RST;
      pass_r  <= PASS_RST;
    end else begin
      case (state_r)
        ST_IDLE: begin
          wait_r <= WAIT_RST;
          pass_r <= PASS_RST;
          if (i_start) begin
            state_r <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (last_wait) begin
            wait_r <= WAIT_RST;
            if (last_pass) begin
              state_r <= ST_CAPTURE;
            end else begin
              pass_r <= pass_r + 3'h1;
            end
          end else begin
            wait_r <= wait_r + 4'h1;
          end
        end
        ST_CAPTURE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Function select and mode drive
  // ************************************************************
  logic [3:0] sel_code;
  logic       mode_code;

  always_comb begin
    sel_code  = SEL_ADD;
    mode_code = MODE_ARITH;
    case (i_op)
      OP_ADD:      sel_code = SEL_ADD;
      OP_SUB:      sel_code = SEL_SUB;
      OP_XOR: begin
        sel_code  = SEL_XOR;
        mode_code = MODE_LOGIC;
      end
      // Single control on lines 0 and 3, lines 1 and 2 held low
      OP_ADD_PASS: sel_code = {i_add_ctrl, 1'b0, 1'b0, i_add_ctrl};
      default:     sel_code = SEL_ADD;
    endcase
  end

  // Operands and codes held steady for the whole operation
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_operand_a         <= '0;
      o_operand_b         <= '0;
      o_function_select_0 <= 1'b0;
      o_function_select_1 <= 1'b0;
      o_function_select_2 <= 1'b0;
      o_function_select_3 <= 1'b0;
      o_mode              <= MODE_ARITH;
    end else if (state_r == ST_IDLE && i_start) begin
      o_operand_a         <= i_a;
      o_operand_b         <= i_b;
      o_function_select_0 <= sel_code[0];
      o_function_select_1 <= sel_code[1];
      o_function_select_2 <= sel_code[2];
      o_function_select_3 <= sel_code[3];
      o_mode              <= mode_code;
    end
  end

  // ************************************************************
  // Ripple carry chain
  // ************************************************************
  // Slow but needs no lookahead package; one filtered pass per slice
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_carry_in <= {N_SLICE{~CARRY_IN_ACTIVE}};
    end else if (state_r == ST_IDLE && i_start) begin
      o_carry_in    <= {N_SLICE{~CARRY_IN_ACTIVE}};
      o_carry_in[0] <= i_carry_active ? CARRY_IN_ACTIVE : ~CARRY_IN_ACTIVE;
    end else if (state_r == ST_SETTLE && last_wait && !last_pass) begin
      o_carry_in[N_SLICE-1:1] <= cout_sync[N_SLICE-2:0];
    end
  end

  // ************************************************************
  // Result capture and status
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_result       <= '0;
      o_carry_active <= 1'b0;
      o_all_ones     <= 1'b0;
      o_equivalent   <= 1'b0;
      o_done         <= 1'b0;
      o_busy         <= 1'b0;
    end else begin
      o_done <= (state_r == ST_CAPTURE);
      o_busy <= (state_r == ST_IDLE) ? i_start : (state_r != ST_CAPTURE);
      if (state_r == ST_CAPTURE) begin
        o_result       <= f_sync;
        // Magnitude flag from the top slice only
        o_carry_active <= (cout_sync[N_SLICE-1] == CARRY_OUT_ACTIVE);
        o_all_ones     <= ones_sync;
        // Auxiliary pair used as is, whatever the operand polarity
        o_equivalent   <= &(gen_sync & prop_sync);
      end
    end
  end

endmodule // alc_host

// file: bench/alc_slice_model.sv
`timescale 1ns/1ps
// ********************************************
// Four behavioural slices, carry-ins from pins
// ********************************************
module alc_slice_model
  import alc_pkg::*;
(
  input  wire logic [15:0] i_a,
  input  wire logic [15:0] i_b,
  input  wire logic [3:0]  i_sel,
  input  wire logic        i_mode,
  input  wire logic [3:0]  i_cin,
  output logic      [15:0] o_f,
  output logic      [3:0]  o_cout,
  output logic      [3:0]  o_gen,
  output logic      [3:0]  o_prop,
  output logic      [3:0]  o_pull_low
);
  logic [3:0] x;
  logic [3:0] y;
  logic [4:0] s;
  // Pure logic, no state; codes not modelled fall back to add
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      x = i_a[4*k +: 4];
      y = (i_sel == SEL_SUB) ? ~i_b[4*k +: 4] : i_b[4*k +: 4];
      if (i_sel == SEL_PASS) y = 4'h0;
      s = x + y + i_cin[k];
      o_f[4*k +: 4] = i_mode ? (x ^ ~y) : s[3:0];
      o_cout[k] = i_mode ? 1'b0 : s[4];
      o_gen[k] = ~|(x & y);
      o_prop[k] = &(x | y);
      o_pull_low[k] = ~&o_f[4*k +: 4];
    end
  end
endmodule // alc_slice_model

// file: bench/alc_host_checker.sv
`timescale 1ns/1ps
// ********************************************
// Host handshake and pin checks
// ********************************************
module alc_host_checker
  import alc_pkg::*;
#(
  parameter int N_SLICE = NUM_SLICES
) (
  input wire logic                       i_clk,
  input wire logic                       i_sys_rst,
  input wire logic                       i_start,
  input wire logic [1:0]                 i_op,
  input wire logic [SLICE_W*N_SLICE-1:0] i_a,
  input wire logic                       i_add_ctrl,
  input wire logic                       o_busy,
  input wire logic                       o_done,
  input wire logic [SLICE_W*N_SLICE-1:0] o_result,
  input wire logic                       o_all_ones,
  input wire logic                       o_equivalent,
  input wire logic [SLICE_W*N_SLICE-1:0] o_operand_a,
  input wire logic                       o_function_select_0,
  input wire logic                       o_function_select_1,
  input wire logic                       o_function_select_2,
  input wire logic                       o_function_select_3,
  input wire logic                       o_mode,
  input wire logic [N_SLICE-1:0]         i_group_generate,
  input wire logic [N_SLICE-1:0]         i_group_propagate
);
  logic       take;
  logic [3:0] sel;
  // Accepted start and packed select pins
  assign take = i_start && !o_busy;
  assign sel  = {o_function_select_3, o_function_select_2, o_function_select_1,
                 o_function_select_0};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  busy_follows_a: assert property (take |=> o_busy)
    else $error("busy missing after start");
  done_latency_a: assert property (take |-> ##22 o_done)
    else $error("done not 22 cycles after start");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  mode_pick_a: assert property (take |=> o_mode == ($past(i_op) == OP_XOR))
    else $error("mode pin wrong for command");
  add_code_a: assert property (take && i_op == OP_ADD |=> sel == SEL_ADD)
    else $error("add select code wrong");
  sub_code_a: assert property (take && i_op == OP_SUB |=> sel == SEL_SUB)
    else $error("subtract select code wrong");
  add_pass_tie_a: assert property (take && i_op == OP_ADD_PASS |=>
    sel == {$past(i_add_ctrl), 2'b00, $past(i_add_ctrl)}) else $error("add-pass tie wrong");
  operand_load_a: assert property (take |=> o_operand_a == $past(i_a))
    else $error("operand pins not loaded");
  all_ones_a: assert property (o_done |-> o_all_ones == &o_result)
    else $error("all-ones flag disagrees with result");
  equiv_and_a: assert property (o_done |->
    o_equivalent == &(i_group_generate & i_group_propagate)) else $error("equivalence wrong");
  cover property (o_done);
  cover property (take && i_op == OP_XOR);
  cover property (take && i_op == OP_ADD_PASS);
endmodule // alc_host_checker

bind alc_host alc_host_checker #(.N_SLICE(N_SLICE)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_start(i_start), .i_op(i_op), .i_a(i_a),
  .i_add_ctrl(i_add_ctrl), .o_busy(o_busy), .o_done(o_done), .o_result(o_result),
  .o_all_ones(o_all_ones), .o_equivalent(o_equivalent), .o_operand_a(o_operand_a),
  .o_function_select_0(o_function_select_0), .o_function_select_1(o_function_select_1),
  .o_function_select_2(o_function_select_2), .o_function_select_3(o_function_select_3),
  .o_mode(o_mode), .i_group_generate(i_group_generate),
  .i_group_propagate(i_group_propagate));

// file: bench/alc_host_tb.sv
`timescale 1ns/1ps
// ********************************************
// Host bench: user commands against modelled slices
// ********************************************
module alc_host_tb;
  import alc_pkg::*;
  logic        clk, rst, start, cin, ctrl, busy, done, cout, ones, equiv, ma;
  logic        s0, s1, s2, s3, wire_eq;
  logic [1:0]  op;
  logic [15:0] a, b, res, pa, pb, f;
  logic [3:0]  pcin, pcout, gen, prop, pull;
  int          n_fail, n_tests;

  // Pull-up on the shared equality wire; any slice may pull it low
  assign wire_eq = ~|pull;

  alc_host dut (.i_clk(clk), .i_sys_rst(rst), .i_start(start), .i_op(op), .i_a(a), .i_b(b),
    .i_carry_active(cin), .i_add_ctrl(ctrl), .o_busy(busy), .o_done(done), .o_result(res),
    .o_carry_active(cout), .o_all_ones(ones), .o_equivalent(equiv), .o_operand_a(pa),
    .o_operand_b(pb), .o_function_select_0(s0), .o_function_select_1(s1),
    .o_function_select_2(s2), .o_function_select_3(s3), .o_mode(ma), .o_carry_in(pcin),
    .i_function_out(f), .i_carry_output(pcout), .i_group_generate(gen),
    .i_group_propagate(prop), .i_all_ones_wire(wire_eq));

  alc_slice_model u_slices (.i_a(pa), .i_b(pb), .i_sel({s3, s2, s1, s0}), .i_mode(ma),
    .i_cin(pcin), .o_f(f), .o_cout(pcout), .o_gen(gen), .o_prop(prop), .o_pull_low(pull));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Start held three cycles: the later two land while busy and must be ignored
  task automatic run(input logic [1:0] o, input logic [15:0] x, y, input logic c, k);
    int n;
    @(negedge clk);
    op = o;
    a = x;
    b = y;
    cin = c;
    ctrl = k;
    start = 1'b1;
    repeat (3) @(negedge clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      n_fail++;
      test_done();
    end
  endtask

  task automatic t_add;
    run(OP_ADD, 16'hffff, 16'h0000, 1'b1, 1'b0);
    check({cout, res}, 20'h10000);
    check(pcin, 4'hf);
    run(OP_ADD, 16'h1234, 16'h0fcd, 1'b0, 1'b0);
    check({cout, res}, 20'h02201);
    check(pb, 16'h0fcd);
  endtask

  task automatic t_cmp;
    logic [15:0] x[3] = '{16'h8000, 16'h4321, 16'h0001};
    logic [15:0] y[3] = '{16'h7fff, 16'h4321, 16'hfffe};
    logic [15:0] r;
    for (int i = 0; i < 3; i++) begin
      for (int c = 0; c < 2; c++) begin
        r = 16'(x[i] - y[i] - 1 + c);
        run(OP_SUB, x[i], y[i], c[0], 1'b0);
        check({cout, res}, {(c ? x[i] >= y[i] : x[i] > y[i]), r});
        check({ones, equiv}, {r == 16'hffff, x[i] == y[i]});
      end
    end
  endtask

  task automatic t_xor;
    run(OP_XOR, 16'h5a5a, 16'ha5a5, 1'b0, 1'b0);
    check({ma, ones, res}, {2'b11, 16'hffff});
    run(OP_XOR, 16'h0ff0, 16'h0ff0, 1'b1, 1'b0);
    check({ma, equiv, res}, {2'b11, 16'h0000});
  endtask

  task automatic t_pass;
    run(OP_ADD_PASS, 16'h1111, 16'h2222, 1'b0, 1'b1);
    check(res, 16'h3333);
    run(OP_ADD_PASS, 16'h1111, 16'h2222, 1'b0, 1'b0);
    check(res, 16'h1111);
  endtask

  // Main sequence: reset, then one task per scenario
  initial begin
    rst = 1'b1;
    start = 1'b0;
    op = 2'h0;
    a = 16'h0000;
    b = 16'h0000;
    cin = 1'b0;
    ctrl = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_add();
    t_cmp();
    t_xor();
    t_pass();
    test_done();
  end
endmodule // alc_host_tb
